// >>> core/smf_config_bank.sv
// file: host configuration bank of the shared memory and flash logical device
`timescale 1ns/1ps
`default_nettype none

module smf_config_bank (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic                      shared_bios_strap,
	input  wire smf_pkg::smf_cfg_req_type  cfg_req,
	output smf_pkg::smf_cfg_resp_type      cfg_resp,
	input  wire logic                      mem_valid,
	input  wire logic [31:0]               mem_addr,
	output logic                           user_window_hit,
	output smf_pkg::smf_cfg_out_type       cfg_out
);

	// ======================================================
	// state and decode signals
	smf_pkg::smf_state_type st;
	smf_pkg::smf_state_type next_st;
	logic                   selected;
	logic                   sel_wr;
	logic                   sel_rd;
	logic                   dec_hit;
	logic [7:0]             read_value;
	logic [15:0]            user_base;

	// bank apart from the device number byte is reachable only under its own device number
	assign selected = (st.device_number == smf_pkg::OWN_DEV_NUM);
	assign sel_wr   = cfg_req.wr && selected;
	assign sel_rd   = cfg_req.rd && selected;
	assign user_base = {st.user_window_base_high, st.user_window_base_low};

	// ======================================================
	// window decoder
	smf_window_decode u_window (
		.enable    (st.shared_memory_config[smf_pkg::POS_USER_EN]),
		.base      (user_base),
		.size_code (st.user_window_size[3:0]),
		.addr      (mem_addr),
		.hit       (dec_hit)
	);

	// ======================================================
	// read mux
	always_comb begin
		read_value = smf_pkg::RST_ZERO;
		case (cfg_req.index)
			smf_pkg::IDX_DEV_NUM:  read_value = st.device_number;
			smf_pkg::IDX_ACTIVATE: read_value = st.device_activate;
			smf_pkg::IDX_IOB0_HI:  read_value = st.io_base0_high;
			smf_pkg::IDX_IOB0_LO:  read_value = st.io_base0_low;
			smf_pkg::IDX_SHM_CFG:  read_value = st.shared_memory_config;
			smf_pkg::IDX_UW_HI:    read_value = st.user_window_base_high;
			smf_pkg::IDX_UW_LO:    read_value = st.user_window_base_low;
			smf_pkg::IDX_UW_SIZE:  read_value = st.user_window_size;
			smf_pkg::IDX_BURST:    read_value = st.host_memory_burst_control;
			default:               read_value = smf_pkg::RST_ZERO;
		endcase
	end

	// ======================================================
	// next state
	always_comb begin
		next_st = st;

		// strap pin through two flops
		next_st.strap_meta = shared_bios_strap;
		next_st.strap_sync = st.strap_meta;

		// catch the strap once the synchroniser has settled
		if (!st.strap_done) begin
			if (st.strap_wait == smf_pkg::STRAP_SETTLE) begin
				next_st.strap_done = 1'b1;
				next_st.shared_memory_config[smf_pkg::POS_FWH_EN]   = st.strap_sync;
				next_st.shared_memory_config[smf_pkg::POS_HOST_MEM] = st.strap_sync;
			end else begin
				next_st.strap_wait = st.strap_wait + 2'h1;
			end
		end

		// host writes; device number is global, the rest need selection
		if (cfg_req.wr && (cfg_req.index == smf_pkg::IDX_DEV_NUM)) begin
			next_st.device_number = cfg_req.wdata;
		end else if (sel_wr) begin
			case (cfg_req.index)
				smf_pkg::IDX_ACTIVATE: begin
					next_st.device_activate = cfg_req.wdata;
				end
				smf_pkg::IDX_IOB0_HI: begin
					next_st.io_base0_high = cfg_req.wdata;
				end
				smf_pkg::IDX_IOB0_LO: begin
					next_st.io_base0_low = cfg_req.wdata & smf_pkg::MSK_IOB0_LO;
				end
				smf_pkg::IDX_SHM_CFG: begin
					next_st.shared_memory_config = cfg_req.wdata;
				end
				smf_pkg::IDX_UW_HI: begin
					next_st.user_window_base_high = cfg_req.wdata;
				end
				smf_pkg::IDX_UW_LO: begin
					next_st.user_window_base_low = cfg_req.wdata;
				end
				smf_pkg::IDX_UW_SIZE: begin
					next_st.user_window_size = cfg_req.wdata & smf_pkg::MSK_UW_SIZE;
				end
				smf_pkg::IDX_BURST: begin
					next_st.host_memory_burst_control = cfg_req.wdata & smf_pkg::MSK_BURST;
				end
				default: begin
					// read-only and unmapped indices drop the write
					next_st.device_activate = st.device_activate;
				end
			endcase
		end

		// read answer one cycle after the strobe
		next_st.resp.rvalid = cfg_req.rd;
		next_st.resp.claim  = cfg_req.rd &&
			(selected || (cfg_req.index == smf_pkg::IDX_DEV_NUM));
		next_st.resp.rdata  = next_st.resp.claim ? read_value : smf_pkg::RST_ZERO;

		// registered memory window hit
		next_st.hit = mem_valid && dec_hit;
	end

	// ======================================================
	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= smf_pkg::ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ======================================================
	// outputs, all from flops
	assign cfg_resp        = st.resp;
	assign user_window_hit = st.hit;

	always_comb begin
		cfg_out.activate                   = st.device_activate;
		cfg_out.io_base0                   = {st.io_base0_high, st.io_base0_low};
		cfg_out.firmware_hub_id            = st.shared_memory_config[smf_pkg::POS_FWH_ID_LSB +: 4];
		cfg_out.firmware_hub_decode_enable = st.shared_memory_config[smf_pkg::POS_FWH_EN];
		cfg_out.user_window_enable         = st.shared_memory_config[smf_pkg::POS_USER_EN];
		cfg_out.extended_bios_range_enable = st.shared_memory_config[smf_pkg::POS_EXT_BIOS];
		cfg_out.host_memory_decode_enable  = st.shared_memory_config[smf_pkg::POS_HOST_MEM];
		cfg_out.user_window_base           = user_base;
		cfg_out.user_window_size_code      = st.user_window_size[3:0];
		cfg_out.burst_threshold            = st.host_memory_burst_control[5:4];
		cfg_out.idle_threshold             = st.host_memory_burst_control[3:0];
	end

	// ======================================================
	// assertion helpers
	logic        wr_cfg_byte;
	logic        wdata_ext;
	logic [15:0] addr_page;

	assign wr_cfg_byte = sel_wr && (cfg_req.index == smf_pkg::IDX_SHM_CFG);
	assign wdata_ext   = cfg_req.wdata[smf_pkg::POS_EXT_BIOS];
	assign addr_page   = mem_addr[31:16];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ======================================================
	// assertions
	property p_foreign_write_ignored;
		cfg_req.wr && !selected && (cfg_req.index != smf_pkg::IDX_DEV_NUM)
			|=> $stable(st.device_activate) && $stable(user_base);
	endproperty
	a_foreign_write_ignored: assert property (p_foreign_write_ignored)
		else $error("write landed while another device was selected");

	property p_activate_write;
		sel_wr && (cfg_req.index == smf_pkg::IDX_ACTIVATE)
			|=> cfg_out.activate == $past(cfg_req.wdata);
	endproperty
	a_activate_write: assert property (p_activate_write)
		else $error("activate byte did not take the written value");

	property p_io_high_write;
		sel_wr && (cfg_req.index == smf_pkg::IDX_IOB0_HI)
			|=> cfg_out.io_base0[15:8] == $past(cfg_req.wdata);
	endproperty
	a_io_high_write: assert property (p_io_high_write)
		else $error("io base high byte did not take the written value");

	property p_io_low_aligned;
		sel_wr && (cfg_req.index == smf_pkg::IDX_IOB0_LO)
			|=> cfg_out.io_base0[7:0] == ($past(cfg_req.wdata) & smf_pkg::MSK_IOB0_LO);
	endproperty
	a_io_low_aligned: assert property (p_io_low_aligned)
		else $error("io base low byte not aligned to sixteen bytes");

	property p_desc1_reads_zero;
		sel_rd && ((cfg_req.index == smf_pkg::IDX_IOB1_HI) ||
			(cfg_req.index == smf_pkg::IDX_IOB1_LO))
			|=> cfg_resp.rvalid && cfg_resp.claim && (cfg_resp.rdata == smf_pkg::RST_ZERO);
	endproperty
	a_desc1_reads_zero: assert property (p_desc1_reads_zero)
		else $error("second io descriptor read not zero");

	property p_irq_reads_zero;
		sel_rd && ((cfg_req.index == smf_pkg::IDX_IRQ_NUM) ||
			(cfg_req.index == smf_pkg::IDX_IRQ_TYPE))
			|=> cfg_resp.rvalid && (cfg_resp.rdata == smf_pkg::RST_ZERO);
	endproperty
	a_irq_reads_zero: assert property (p_irq_reads_zero)
		else $error("interrupt byte read not zero");

	property p_cfg_byte_write;
		wr_cfg_byte |=> st.shared_memory_config == $past(cfg_req.wdata);
	endproperty
	a_cfg_byte_write: assert property (p_cfg_byte_write)
		else $error("config byte did not take the written value");

	property p_strap_defaults;
		$rose(st.strap_done) && !$past(wr_cfg_byte)
			|-> (cfg_out.firmware_hub_decode_enable == $past(st.strap_sync)) &&
				(cfg_out.host_memory_decode_enable == $past(st.strap_sync));
	endproperty
	a_strap_defaults: assert property (p_strap_defaults)
		else $error("decode enables did not follow the strap");

	property p_ext_bios_write;
		wr_cfg_byte |=> cfg_out.extended_bios_range_enable == $past(wdata_ext);
	endproperty
	a_ext_bios_write: assert property (p_ext_bios_write)
		else $error("extended bios enable did not follow the write");

	property p_hit_needs_enable;
		user_window_hit |-> $past(cfg_out.user_window_enable) && $past(mem_valid);
	endproperty
	a_hit_needs_enable: assert property (p_hit_needs_enable)
		else $error("window hit without enable or cycle");

	property p_base_match;
		user_window_hit && ($past(cfg_out.user_window_size_code) == 4'h0)
			|-> $past(addr_page) == $past(user_base);
	endproperty
	a_base_match: assert property (p_base_match)
		else $error("smallest window hit outside its base page");

	property p_reserved_size;
		user_window_hit |-> $past(st.user_window_size) <= smf_pkg::UW_SIZE_MAX;
	endproperty
	a_reserved_size: assert property (p_reserved_size)
		else $error("window hit under a reserved size code");

	// ======================================================
	// selection, answer timing and per byte write checks
	property p_dev_num_write;
		cfg_req.wr && (cfg_req.index == smf_pkg::IDX_DEV_NUM)
			|=> st.device_number == $past(cfg_req.wdata);
	endproperty
	a_dev_num_write: assert property (p_dev_num_write)
		else $error("device number write did not land");

	property p_foreign_read;
		cfg_req.rd && !selected && (cfg_req.index != smf_pkg::IDX_DEV_NUM)
			|=> cfg_resp.rvalid && !cfg_resp.claim &&
				(cfg_resp.rdata == smf_pkg::RST_ZERO);
	endproperty
	a_foreign_read: assert property (p_foreign_read)
		else $error("read claimed while another device was selected");

	property p_answer_next_cycle;
		cfg_req.rd |=> cfg_resp.rvalid;
	endproperty
	a_answer_next_cycle: assert property (p_answer_next_cycle)
		else $error("read answer missing one cycle after the strobe");

	property p_ro_write_dropped;
		sel_wr && ((cfg_req.index == smf_pkg::IDX_IOB1_HI) ||
			(cfg_req.index == smf_pkg::IDX_IOB1_LO) ||
			(cfg_req.index == smf_pkg::IDX_IRQ_NUM) ||
			(cfg_req.index == smf_pkg::IDX_IRQ_TYPE))
			|=> $stable(cfg_out.activate) && $stable(cfg_out.io_base0) && $stable(user_base);
	endproperty
	a_ro_write_dropped: assert property (p_ro_write_dropped)
		else $error("write to a read-only byte changed a register");

	property p_user_en_write;
		wr_cfg_byte
			|=> cfg_out.user_window_enable == $past(cfg_req.wdata[smf_pkg::POS_USER_EN]);
	endproperty
	a_user_en_write: assert property (p_user_en_write)
		else $error("user window enable did not follow the write");

	property p_base_high_write;
		sel_wr && (cfg_req.index == smf_pkg::IDX_UW_HI)
			|=> cfg_out.user_window_base[15:8] == $past(cfg_req.wdata);
	endproperty
	a_base_high_write: assert property (p_base_high_write)
		else $error("window base high byte did not take the written value");

	property p_base_low_write;
		sel_wr && (cfg_req.index == smf_pkg::IDX_UW_LO)
			|=> cfg_out.user_window_base[7:0] == $past(cfg_req.wdata);
	endproperty
	a_base_low_write: assert property (p_base_low_write)
		else $error("window base low byte did not take the written value");

	property p_size_write;
		sel_wr && (cfg_req.index == smf_pkg::IDX_UW_SIZE)
			|=> st.user_window_size == ($past(cfg_req.wdata) & smf_pkg::MSK_UW_SIZE);
	endproperty
	a_size_write: assert property (p_size_write)
		else $error("window size byte did not take the masked value");

	property p_hit_when_match;
		mem_valid && cfg_out.user_window_enable && (cfg_out.user_window_size_code == 4'h0) &&
			(addr_page == user_base) |=> user_window_hit;
	endproperty
	a_hit_when_match: assert property (p_hit_when_match)
		else $error("matching cycle in the smallest window gave no hit");

	// ======================================================
	// covers
	c_strap_loaded: cover property ($rose(st.strap_done) && st.strap_sync);
	c_user_hit:     cover property (user_window_hit);
	c_cfg_read:     cover property (sel_rd && (cfg_req.index == smf_pkg::IDX_SHM_CFG));
	c_foreign_wr:   cover property (cfg_req.wr && !selected &&
		(cfg_req.index == smf_pkg::IDX_ACTIVATE));
	c_reserved:     cover property (mem_valid && cfg_out.user_window_enable &&
		({4'h0, cfg_out.user_window_size_code} > smf_pkg::UW_SIZE_MAX));

endmodule : smf_config_bank

`default_nettype wire

// >>> core/smf_pkg.sv
// package: index map, reset values and carrier types of the shared memory config bank
package smf_pkg;

	// ======================================================
	// configuration indices
	localparam logic [7:0] IDX_DEV_NUM  = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_IOB0_HI  = 8'h60;
	localparam logic [7:0] IDX_IOB0_LO  = 8'h61;
	localparam logic [7:0] IDX_IOB1_HI  = 8'h62;
	localparam logic [7:0] IDX_IOB1_LO  = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUM  = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_SHM_CFG  = 8'hf4;
	localparam logic [7:0] IDX_UW_HI    = 8'hf5;
	localparam logic [7:0] IDX_UW_LO    = 8'hf6;
	localparam logic [7:0] IDX_UW_SIZE  = 8'hf7;
	localparam logic [7:0] IDX_BURST    = 8'hf8;

	// number that selects this logical device
	localparam logic [7:0] OWN_DEV_NUM = 8'h0f;

	// ======================================================
	// reset values and writable masks
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_BURST  = 8'h18;
	localparam logic [7:0] MSK_IOB0_LO = 8'hf0;
	localparam logic [7:0] MSK_UW_SIZE = 8'h0f;
	localparam logic [7:0] MSK_BURST   = 8'h3f;

	// ======================================================
	// field positions of the shared memory configuration byte
	localparam int unsigned POS_FWH_ID_LSB = 4;
	localparam int unsigned POS_FWH_EN     = 3;
	localparam int unsigned POS_USER_EN    = 2;
	localparam int unsigned POS_EXT_BIOS   = 1;
	localparam int unsigned POS_HOST_MEM   = 0;

	// ======================================================
	// window decode and strap timing
	localparam logic [7:0] UW_SIZE_MAX  = 8'h05;
	localparam int unsigned WIN_LSB     = 16;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ======================================================
	// carrier types
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} smf_cfg_req_type;

	typedef struct packed {
		logic       rvalid;
		logic       claim;
		logic [7:0] rdata;
	} smf_cfg_resp_type;

	typedef struct packed {
		logic [7:0]  activate;
		logic [15:0] io_base0;
		logic [3:0]  firmware_hub_id;
		logic        firmware_hub_decode_enable;
		logic        user_window_enable;
		logic        extended_bios_range_enable;
		logic        host_memory_decode_enable;
		logic [15:0] user_window_base;
		logic [3:0]  user_window_size_code;
		logic [1:0]  burst_threshold;
		logic [3:0]  idle_threshold;
	} smf_cfg_out_type;

	typedef struct packed {
		logic [7:0]       device_number;
		logic [7:0]       device_activate;
		logic [7:0]       io_base0_high;
		logic [7:0]       io_base0_low;
		logic [7:0]       shared_memory_config;
		logic [7:0]       user_window_base_high;
		logic [7:0]       user_window_base_low;
		logic [7:0]       user_window_size;
		logic [7:0]       host_memory_burst_control;
		logic             strap_meta;
		logic             strap_sync;
		logic [1:0]       strap_wait;
		logic             strap_done;
		smf_cfg_resp_type resp;
		logic             hit;
	} smf_state_type;

	localparam smf_state_type ST_RESET = '{
		host_memory_burst_control: RST_BURST,
		strap_wait:                2'h0,
		resp:                      '0,
		default:                   '0
	};

endpackage : smf_pkg

// >>> core/smf_window_decode.sv
// file: user memory window address match
`timescale 1ns/1ps
`default_nettype none

module smf_window_decode (
	input  wire logic        enable,
	input  wire logic [15:0] base,
	input  wire logic [3:0]  size_code,
	input  wire logic [31:0] addr,
	output logic             hit
);

	logic [15:0] bit_ok;

	// ======================================================
	// per page bit: masked below the size, else must match base
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_bit
			assign bit_ok[i] = (4'(i) < size_code) ||
				(addr[smf_pkg::WIN_LSB + i] == base[i]);
		end
	endgenerate

	// reserved size codes never match
	assign hit = enable && ({4'h0, size_code} <= smf_pkg::UW_SIZE_MAX) && (&bit_ok);

endmodule : smf_window_decode

`default_nettype wire

// >>> verification/smf_host_model.sv
// host side model: index-data configuration cycles
`timescale 1ns/1ps
`default_nettype none

module smf_host_model (
	input  wire logic                      clk_sys,
	output var smf_pkg::smf_cfg_req_type   cfg_req,
	input  wire smf_pkg::smf_cfg_resp_type cfg_resp
);
	// ==========================================
	// idle at time zero
	initial begin
		cfg_req = '0;
	end

	// write cycle; released lines flip so no stale value is seen
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge clk_sys);
		cfg_req = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
		@(negedge clk_sys);
		cfg_req = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~d};
	endtask : wr

	// read cycle; answer stands from the taking edge on, sampled half a cycle later
	task automatic rd(input logic [7:0] idx, output smf_pkg::smf_cfg_resp_type r);
		@(negedge clk_sys);
		cfg_req = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h5a};
		@(negedge clk_sys);
		r = cfg_resp;
		cfg_req = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: 8'ha5};
	endtask : rd

	// device number goes first
	task automatic sel(input logic [7:0] num);
		wr(8'h07, num);
	endtask : sel
endmodule : smf_host_model
`default_nettype wire

// >>> verification/tb_smf_config_bank.sv
// testbench of the shared memory configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb_smf_config_bank;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] exp;
		logic [7:0] rst;
	} smf_row_type;
	typedef struct packed {
		logic [7:0]  code;
		logic [31:0] addr;
		logic        exp;
	} smf_win_type;

	// ==========================================
	// index, write, readback, reset value
	localparam smf_row_type rows [12] = '{
		'{8'h30, 8'hff, 8'hff, 8'h00}, '{8'h60, 8'ha5, 8'ha5, 8'h00},
		'{8'h61, 8'hff, 8'hf0, 8'h00}, '{8'h62, 8'hff, 8'h00, 8'h00},
		'{8'h63, 8'hff, 8'h00, 8'h00}, '{8'h70, 8'hff, 8'h00, 8'h00},
		'{8'h71, 8'hff, 8'h00, 8'h00}, '{8'hf4, 8'hf6, 8'hf6, 8'h09},
		'{8'hf5, 8'h12, 8'h12, 8'h00}, '{8'hf6, 8'h34, 8'h34, 8'h00},
		'{8'hf7, 8'hff, 8'h0f, 8'h00}, '{8'hf8, 8'hff, 8'h3f, 8'h18}};
	// size code, address, hit with base 1234h
	localparam smf_win_type wins [8] = '{
		'{8'h0f, 32'h12340000, 1'b0}, '{8'h00, 32'h12340000, 1'b1},
		'{8'h00, 32'h12350000, 1'b0}, '{8'h01, 32'h12350000, 1'b1},
		'{8'h01, 32'h12360000, 1'b0}, '{8'h05, 32'h12200000, 1'b1},
		'{8'h05, 32'h12400000, 1'b0}, '{8'h05, 32'h121f0000, 1'b0}};

	logic                      clk_sys;
	logic                      rst_n;
	logic                      strap;
	logic                      mem_valid;
	logic [31:0]               mem_addr;
	logic                      hit;
	smf_pkg::smf_cfg_req_type  cfg_req;
	smf_pkg::smf_cfg_resp_type cfg_resp;
	smf_pkg::smf_cfg_resp_type r;
	smf_pkg::smf_cfg_out_type  cfg_out;
	smf_pkg::smf_cfg_out_type  e;
	int                        errors;
	int                        compares;

	smf_config_bank i_smf_config_bank (
		.clk_sys(clk_sys), .rst_n(rst_n), .shared_bios_strap(strap),
		.cfg_req(cfg_req), .cfg_resp(cfg_resp), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .user_window_hit(hit), .cfg_out(cfg_out));
	smf_host_model i_smf_host_model (
		.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_resp(cfg_resp));

	// ==========================================
	// compare and closing tasks
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %0t byte %h expected %h", $time, g, x);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic g, input logic x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %0t bit %b expected %b", $time, g, x);
		end
	endtask : chk_bit
	task automatic chk_out(input smf_pkg::smf_cfg_out_type g, input smf_pkg::smf_cfg_out_type x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %0t fields %h expected %h", $time, g, x);
		end
	endtask : chk_out
	task automatic conclude();
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	// one host memory cycle, hit looked at one cycle later
	task automatic mem(input logic [31:0] a, input logic x);
		@(negedge clk_sys);
		mem_valid = 1'b1;
		mem_addr = a;
		@(negedge clk_sys);
		mem_valid = 1'b0;
		mem_addr = ~a;
		chk_bit(hit, x);
	endtask : mem

	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		errors++;
		conclude();
	end

	// ==========================================
	// main sequence
	initial begin
		errors = 0;
		compares = 0;
		rst_n = 1'b0;
		strap = 1'b1;
		mem_valid = 1'b0;
		mem_addr = '0;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		// unselected: no claim, writes dropped
		i_smf_host_model.rd(8'h30, r);
		chk_bit(r.rvalid, 1'b1);
		chk_bit(r.claim, 1'b0);
		chk_byte(r.rdata, 8'h00);
		i_smf_host_model.wr(8'h30, 8'hff);
		i_smf_host_model.sel(8'h0e);
		i_smf_host_model.wr(8'h30, 8'hff);
		i_smf_host_model.sel(smf_pkg::OWN_DEV_NUM);
		i_smf_host_model.rd(8'h07, r);
		chk_byte(r.rdata, 8'h0f);
		for (int i = 0; i < 12; i++) begin
			i_smf_host_model.rd(rows[i].idx, r);
			chk_byte(r.rdata, rows[i].rst);
		end
		for (int i = 0; i < 12; i++) begin
			i_smf_host_model.wr(rows[i].idx, rows[i].wd);
			i_smf_host_model.rd(rows[i].idx, r);
			chk_byte(r.rdata, rows[i].exp);
			chk_bit(r.claim, 1'b1);
		end
		e = '{activate: 8'hff, io_base0: 16'ha5f0, firmware_hub_id: 4'hf,
			firmware_hub_decode_enable: 1'b0, user_window_enable: 1'b1,
			extended_bios_range_enable: 1'b1, host_memory_decode_enable: 1'b0,
			user_window_base: 16'h1234, user_window_size_code: 4'hf,
			burst_threshold: 2'h3, idle_threshold: 4'hf};
		chk_out(cfg_out, e);
		// window decode over size codes
		for (int i = 0; i < 8; i++) begin
			i_smf_host_model.wr(8'hf7, wins[i].code);
			mem(wins[i].addr, wins[i].exp);
		end
		i_smf_host_model.wr(8'hf4, 8'h00);
		mem(32'h12200000, 1'b0);
		// second reset with the strap low
		@(negedge clk_sys);
		rst_n = 1'b0;
		strap = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		i_smf_host_model.rd(8'hf4, r);
		chk_bit(r.claim, 1'b0);
		i_smf_host_model.sel(smf_pkg::OWN_DEV_NUM);
		i_smf_host_model.rd(8'hf4, r);
		chk_byte(r.rdata, 8'h00);
		conclude();
	end
endmodule : tb_smf_config_bank
`default_nettype wire
